// *** logic/srcr_pkg.sv ***
// Constants shared by the sensing-range configuration register bank.
package srcr_pkg;
	// Width of the register address and of every register.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// Field position: each register holds one field in bits 7 to 0.
	localparam int FIELD_MSB = 7;
	localparam int FIELD_LSB = 0;
	// Number of configuration entries held by this bank.
	localparam int NUM_CFG = 2;
	// Entry indices inside the bank.
	localparam int IDX_MIN_RES = 0;
	localparam int IDX_MIN_FREQ = 1;
	// Register offsets.
	localparam logic [7:0] MIN_RESISTANCE_RANGE_OFFSET = 8'h02;
	localparam logic [7:0] MIN_RESONANT_FREQUENCY_OFFSET = 8'h03;
	// Reset values.
	localparam logic [7:0] MIN_RESISTANCE_RANGE_RESET = 8'h14;
	localparam logic [7:0] MIN_RESONANT_FREQUENCY_RESET = 8'h45;
	// Offsets and resets per entry, in entry order.
	localparam logic [7:0] CFG_OFFSET [NUM_CFG] = '{MIN_RESISTANCE_RANGE_OFFSET,
		MIN_RESONANT_FREQUENCY_OFFSET};
	localparam logic [7:0] CFG_RESET [NUM_CFG] = '{MIN_RESISTANCE_RANGE_RESET,
		MIN_RESONANT_FREQUENCY_RESET};
	// Valid resistance codes; code 0x20 is the highest resistance.
	localparam logic [7:0] MIN_RES_CODE_LO = 8'h20;
	localparam logic [7:0] MIN_RES_CODE_HI = 8'h3f;
	// Width of the resistance step index handed to the front end.
	localparam int RANGE_IDX_W = 5;
	// Span of configuration offsets that active mode locks.
	localparam logic [7:0] LOCK_FIRST_OFFSET = 8'h01;
	localparam logic [7:0] LOCK_LAST_OFFSET = 8'h05;
	// Value returned for an offset this bank does not hold.
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
endpackage

// *** logic/srcr_regs.sv ***
// Minimum resistance range and minimum resonant frequency configuration registers.
`timescale 1ns/1ps

module srcr_regs (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register access port from the serial interface decoder.
	input wire logic [7:0] addr_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic rd_en_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic wr_ignored_o,
	// Power mode bit held by the power configuration register.
	input wire logic active_mode_select_i,
	// Configuration handed to the measurement front end.
	output logic [7:0] min_resistance_range_o,
	output logic [7:0] min_resonant_frequency_o,
	output logic min_res_code_valid_o,
	output logic [4:0] min_res_range_idx_o
);

	// Stored field of each entry.
	logic [7:0] cfg_reg [srcr_pkg::NUM_CFG];
	// Per-entry address match.
	logic [srcr_pkg::NUM_CFG-1:0] hit;
	// Per-entry accepted write strobe.
	logic [srcr_pkg::NUM_CFG-1:0] wr_hit;
	// Read data register and its next value.
	logic [7:0] rd_data_reg;
	logic [7:0] rd_data_next;
	// Read acknowledge register.
	logic rd_valid_reg;
	// Decoded resistance range registers.
	logic code_valid_reg;
	logic code_valid_next;
	logic [4:0] range_idx_reg;
	logic [4:0] range_idx_next;
	// Next value of the resistance field, used to decode ahead of the store.
	logic [7:0] min_res_next;

	// Writes into the locked span are dropped while measurement is active.
	wire logic in_lock_span = (addr_i >= srcr_pkg::LOCK_FIRST_OFFSET) &&
		(addr_i <= srcr_pkg::LOCK_LAST_OFFSET);
	wire logic wr_locked = active_mode_select_i && in_lock_span;
	wire logic wr_allowed = wr_en_i && !wr_locked;

	// Each entry decodes its own offset and keeps its own field.
	genvar gi;
	generate
		for (gi = 0; gi < srcr_pkg::NUM_CFG; gi++) begin : g_cfg
			// Address match for this entry.
			assign hit[gi] = (addr_i == srcr_pkg::CFG_OFFSET[gi]);
			// Accepted write for this entry.
			assign wr_hit[gi] = wr_allowed && hit[gi];
			// The field loads only on an accepted write, so it keeps the last one.
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					cfg_reg[gi] <= srcr_pkg::CFG_RESET[gi];
				end else if (wr_hit[gi]) begin
					cfg_reg[gi] <= wr_data_i;
				end
			end
		end
	endgenerate

	// Read multiplexer; an offset outside the bank reads as zero.
	assign rd_data_next = hit[srcr_pkg::IDX_MIN_RES] ? cfg_reg[srcr_pkg::IDX_MIN_RES] :
		hit[srcr_pkg::IDX_MIN_FREQ] ? cfg_reg[srcr_pkg::IDX_MIN_FREQ] :
		srcr_pkg::UNMAPPED_READ_VALUE;

	// Read data is captured on the request edge and held until the next read.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_data_reg <= 8'h00;
		end else if (rd_en_i) begin
			rd_data_reg <= rd_data_next;
		end
	end

	// Read acknowledge follows the request by one cycle.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= rd_en_i;
		end
	end

	// Resistance field as it will stand after this edge.
	assign min_res_next = wr_hit[srcr_pkg::IDX_MIN_RES] ? wr_data_i :
		cfg_reg[srcr_pkg::IDX_MIN_RES];

	// A code is usable only inside the table; index 0 selects the highest resistance.
	assign code_valid_next = (min_res_next >= srcr_pkg::MIN_RES_CODE_LO) &&
		(min_res_next <= srcr_pkg::MIN_RES_CODE_HI);
	assign range_idx_next = code_valid_next ?
		min_res_next[4:0] : 5'h00;

	// Decoded lower bound of the input range, kept in step with the field.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			code_valid_reg <= 1'b0;
			range_idx_reg <= 5'h00;
		end else begin
			code_valid_reg <= code_valid_next;
			range_idx_reg <= range_idx_next;
		end
	end

	// Port drive; the refusal flag is a plain handshake decode.
	assign rd_data_o = rd_data_reg;
	assign rd_valid_o = rd_valid_reg;
	assign wr_ignored_o = wr_en_i && wr_locked;
	assign min_resistance_range_o = cfg_reg[srcr_pkg::IDX_MIN_RES];
	// The frequency code is computed by host software and used as stored.
	assign min_resonant_frequency_o = cfg_reg[srcr_pkg::IDX_MIN_FREQ];
	assign min_res_code_valid_o = code_valid_reg;
	assign min_res_range_idx_o = range_idx_reg;

	// Set one edge after reset release, so that look-back checks skip the reset edge.
	logic past_ok;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			past_ok <= 1'b0;
		end else begin
			past_ok <= 1'b1;
		end
	end

	// Reset leaves both fields at their documented values.
	chk_reset_values: assert property (@(posedge clk_i)
		!rst_n_i |=> (min_resistance_range_o == srcr_pkg::MIN_RESISTANCE_RANGE_RESET) &&
		(min_resonant_frequency_o == srcr_pkg::MIN_RESONANT_FREQUENCY_RESET))
		else $error("Configuration fields not at reset values after reset.");

	// An accepted frequency write lands on the next edge.
	chk_freq_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_en_i && !active_mode_select_i &&
		(addr_i == srcr_pkg::MIN_RESONANT_FREQUENCY_OFFSET) |=>
		min_resonant_frequency_o == $past(wr_data_i))
		else $error("Frequency field did not take the permitted write.");

	// Any write in active mode leaves both fields unchanged.
	chk_active_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_en_i && active_mode_select_i |=>
		$stable(min_resistance_range_o) && $stable(min_resonant_frequency_o))
		else $error("Field changed on a write during active mode.");

	// A field moves only because of a permitted write at its offset.
	chk_field_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i || !past_ok)
		$changed(min_resistance_range_o) |->
		$past(wr_en_i) && !$past(active_mode_select_i) &&
		($past(addr_i) == srcr_pkg::MIN_RESISTANCE_RANGE_OFFSET))
		else $error("Resistance field changed without a permitted write.");

	// Read of the resistance offset returns the field one cycle later.
	chk_read_returns: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_en_i && !wr_en_i && (addr_i == srcr_pkg::MIN_RESISTANCE_RANGE_OFFSET) |=>
		rd_valid_o && (rd_data_o == min_resistance_range_o))
		else $error("Read did not return the stored resistance field.");

	// The decoded range follows the field with no lag.
	chk_range_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i || !past_ok)
		min_res_code_valid_o == ((min_resistance_range_o >= srcr_pkg::MIN_RES_CODE_LO) &&
		(min_resistance_range_o <= srcr_pkg::MIN_RES_CODE_HI)))
		else $error("Range valid flag disagrees with resistance field.");

	// A valid code maps to its offset from the lowest table code.
	chk_range_index: assert property (@(posedge clk_i) disable iff (!rst_n_i || !past_ok)
		min_res_code_valid_o |->
		({3'h1, min_res_range_idx_o} == min_resistance_range_o))
		else $error("Range index does not match resistance code.");

	// A permitted write to the resistance offset lands on the next edge.
	chk_res_write_lands: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_en_i && !active_mode_select_i &&
		(addr_i == srcr_pkg::MIN_RESISTANCE_RANGE_OFFSET) |=>
		min_resistance_range_o == $past(wr_data_i))
		else $error("Resistance field did not take the permitted write.");

	// The frequency field also moves only because of a permitted write.
	chk_freq_cause: assert property (@(posedge clk_i) disable iff (!rst_n_i || !past_ok)
		$changed(min_resonant_frequency_o) |->
		$past(wr_en_i) && !$past(active_mode_select_i) &&
		($past(addr_i) == srcr_pkg::MIN_RESONANT_FREQUENCY_OFFSET))
		else $error("Frequency field changed without a permitted write.");

	// Read of the frequency offset returns the field one cycle later.
	chk_read_freq: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_en_i && !wr_en_i && (addr_i == srcr_pkg::MIN_RESONANT_FREQUENCY_OFFSET) |=>
		rd_valid_o && (rd_data_o == min_resonant_frequency_o))
		else $error("Read did not return the stored frequency field.");

	// An offset outside the bank reads as the fixed unmapped value.
	chk_read_unmapped: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rd_en_i && (addr_i != srcr_pkg::MIN_RESISTANCE_RANGE_OFFSET) &&
		(addr_i != srcr_pkg::MIN_RESONANT_FREQUENCY_OFFSET) |=>
		rd_data_o == srcr_pkg::UNMAPPED_READ_VALUE)
		else $error("Unmapped read did not return the fixed value.");

	// Every read is acknowledged once, one cycle after its request.
	chk_read_ack: assert property (@(posedge clk_i) disable iff (!rst_n_i || !past_ok)
		rd_valid_o == $past(rd_en_i))
		else $error("Read acknowledge does not follow the read request.");

	// A write to either field is flagged as refused exactly when active mode locks it.
	chk_lock_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_en_i && ((addr_i == srcr_pkg::MIN_RESISTANCE_RANGE_OFFSET) ||
		(addr_i == srcr_pkg::MIN_RESONANT_FREQUENCY_OFFSET)) |->
		wr_ignored_o == active_mode_select_i)
		else $error("Refusal flag disagrees with the power mode bit.");

endmodule

// *** verification/srcr_host.sv ***
// Host model that drives the register port of the configuration bank.
`timescale 1ns/1ps
module srcr_host (
	// Clock.
	input wire logic clk_i,
	// Request side.
	output logic [7:0] addr_o,
	output logic wr_en_o,
	output logic [7:0] wr_data_o,
	output logic rd_en_o,
	output logic act_o,
	// Answer side.
	input wire logic [7:0] rd_data_i,
	input wire logic rd_valid_i,
	input wire logic wr_ignored_i
);
	// The bus is idle at time zero.
	initial begin
		{addr_o, wr_en_o, wr_data_o, rd_en_o, act_o} = '0;
	end
	// One access, driven at a falling edge and held for one cycle.
	task automatic access(input logic w, input logic act, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic [1:0] st);
		@(negedge clk_i);
		{act_o, addr_o, wr_data_o, wr_en_o, rd_en_o} = {act, a, d, w, !w};
		#1 st[0] = wr_ignored_i;
		@(negedge clk_i);
		st[1] = rd_valid_i;
		q = rd_valid_i ? rd_data_i : 8'hff;
		// Released address and data lines show the inverse and both strobes drop, so a stale copy cannot pass.
		{addr_o, wr_data_o, wr_en_o, rd_en_o} = {~a, ~d, 2'b00};
	endtask
	// Code for a target 20% below the sensor's lowest frequency.
	function automatic logic [7:0] freq_code(input real fs);
		freq_code = 8'($rtoi(68.94 * $log10(0.8 * fs / 2000.0) + 0.5));
	endfunction
endmodule

// *** verification/srcr_regs_tb.sv ***
// Self-checking bench for the configuration register bank.
`timescale 1ns/1ps
module srcr_regs_tb;
	// One access and the answer it should give.
	typedef struct packed {logic w; logic act; logic [7:0] a; logic [7:0] d;
		logic [7:0] q; logic [1:0] st;} srcr_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr, wr_data, rd_data, res, freq, q;
	logic wr_en, rd_en, rd_valid, wr_ign, act, cval;
	logic [4:0] idx;
	logic [1:0] st;
	int mismatches = 0;
	int total_checks = 0;
	srcr_row_t rows [16] = '{
		{1'b1, 1'b0, 8'h02, 8'h25, 8'hff, 2'b00}, {1'b0, 1'b0, 8'h02, 8'h00, 8'h25, 2'b10},
		{1'b0, 1'b0, 8'h03, 8'h00, 8'h45, 2'b10}, {1'b1, 1'b0, 8'h03, 8'hb3, 8'hff, 2'b00},
		{1'b0, 1'b0, 8'h03, 8'h00, 8'hb3, 2'b10}, {1'b1, 1'b1, 8'h02, 8'h3f, 8'hff, 2'b01},
		{1'b0, 1'b1, 8'h02, 8'h00, 8'h25, 2'b10}, {1'b1, 1'b1, 8'h06, 8'h11, 8'hff, 2'b00},
		{1'b0, 1'b1, 8'h05, 8'h00, 8'h00, 2'b10}, {1'b1, 1'b1, 8'h05, 8'h11, 8'hff, 2'b01},
		{1'b1, 1'b1, 8'h01, 8'h11, 8'hff, 2'b01}, {1'b1, 1'b1, 8'h00, 8'h11, 8'hff, 2'b00},
		{1'b1, 1'b1, 8'h03, 8'h11, 8'hff, 2'b01}, {1'b0, 1'b1, 8'h03, 8'h00, 8'hb3, 2'b10},
		{1'b1, 1'b0, 8'h02, 8'h3f, 8'hff, 2'b00}, {1'b0, 1'b0, 8'h02, 8'h00, 8'h3f, 2'b10}};
	// A 40 MHz clock.
	always #12.5 clk = ~clk;
	srcr_regs srcr_regs_i (.clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wr_en_i(wr_en),
		.wr_data_i(wr_data), .rd_en_i(rd_en), .rd_data_o(rd_data), .rd_valid_o(rd_valid),
		.wr_ignored_o(wr_ign), .active_mode_select_i(act), .min_resistance_range_o(res),
		.min_resonant_frequency_o(freq), .min_res_code_valid_o(cval),
		.min_res_range_idx_o(idx));
	srcr_host srcr_host_i (.clk_i(clk), .addr_o(addr), .wr_en_o(wr_en), .wr_data_o(wr_data),
		.rd_en_o(rd_en), .act_o(act), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
		.wr_ignored_i(wr_ign));
	// Compares one byte and counts it.
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Prints the counts and the verdict, then ends the run.
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Main sequence: reset, the table, code range, reset in mid-run.
	initial begin
		repeat (5) @(negedge clk);
		check(res, 8'h14);
		check(freq, 8'h45);
		check({cval, 2'b00, idx}, 8'h00);
		rst_n = 1'b1;
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			srcr_host_i.access(rows[i].w, rows[i].act, rows[i].a, rows[i].d, q, st);
			check(q, rows[i].q);
			check({6'h00, st}, {6'h00, rows[i].st});
		end
		$display("test table done");
		check(srcr_host_i.freq_code(1.0e6), 8'hb3);
		check({cval, 2'b00, idx}, 8'h9f);
		srcr_host_i.access(1'b1, 1'b0, 8'h02, 8'h40, q, st);
		check({cval, 2'b00, idx}, 8'h00);
		srcr_host_i.access(1'b1, 1'b0, 8'h02, 8'h20, q, st);
		check({cval, 2'b00, idx}, 8'h80);
		$display("test code range done");
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		check(res, 8'h14);
		check(freq, 8'h45);
		check(rd_data, 8'h00);
		check({7'h00, rd_valid}, 8'h00);
		rst_n = 1'b1;
		srcr_host_i.access(1'b0, 1'b0, 8'h02, 8'h00, q, st);
		check(q, 8'h14);
		check({6'h00, st}, 8'h02);
		check({cval, 2'b00, idx}, 8'h00);
		$display("test mid reset done");
		print_verdict();
	end
	// The tests need about 45 cycles; cut a hang short well beyond that.
	initial begin
		#(25 * 400);
		mismatches++;
		$display("test watchdog expired");
		print_verdict();
	end
endmodule
